// ---- verilog/oled_pkg.sv ----
// constants shared by the row scan timing core and its pixel memory
// assumes a single 20 MHz system clock; all times are turned into cycles here
package oled_pkg;
	// system clock
	localparam int CLOCK_HZ = 20_000_000;
	// display on delay in milliseconds, then in system clocks (exact division)
	localparam int DISPLAY_ON_DELAY_MS = 100;
	localparam int DISPLAY_ON_DELAY_CYCLES = (CLOCK_HZ / 1000) * DISPLAY_ON_DELAY_MS;
	// panel geometry
	localparam int PANEL_COLUMNS = 320;
	localparam int PANEL_ROWS = 160;
	localparam int BYTES_PER_ROW = PANEL_COLUMNS / 2;
	localparam int PIXEL_BYTES = BYTES_PER_ROW * PANEL_ROWS;
	// shortest span of phases three and four together, in display clocks
	localparam logic [6:0] DRIVE_CLOCKS = 7'h48;
	// gray table step of the linear table and widest setting
	localparam logic [5:0] GRAY_STEP = 6'h04;
	localparam logic [5:0] GRAY_MAX = 6'h3F;
	// reset values of the command registers
	localparam logic [7:0] MUX_RESET = 8'h9F;
	localparam logic [7:0] CONTRAST_RESET = 8'h7F;
	localparam logic [7:0] CLOCK_SETUP_RESET = 8'h10;
	localparam logic [7:0] PHASE_RESET = 8'h74;
	localparam logic [7:0] PHASE3_RESET = 8'h08;
	// oscillator period base, in system clocks, reduced by the frequency nibble
	localparam logic [4:0] OSC_PERIOD_BASE = 5'h11;
	// command opcodes
	localparam logic [7:0] CMD_CLOCK_SETUP = 8'hB3;
	localparam logic [7:0] CMD_PHASE_LENGTH = 8'hB1;
	localparam logic [7:0] CMD_PHASE3 = 8'hB6;
	localparam logic [7:0] CMD_GRAY_LOAD = 8'hB8;
	localparam logic [7:0] CMD_GRAY_LINEAR = 8'hB9;
	localparam logic [7:0] CMD_MUX = 8'hCA;
	localparam logic [7:0] CMD_CONTRAST = 8'hC1;
	localparam logic [7:0] CMD_DISPLAY_ON = 8'hAF;
	localparam logic [7:0] CMD_DISPLAY_OFF = 8'hAE;
	localparam logic [7:0] CMD_NORMAL = 8'hA6;
	localparam logic [7:0] CMD_INVERSE = 8'hA7;
	// number of parameter bytes of the gray table load
	localparam logic [4:0] GRAY_LOAD_BYTES = 5'h0F;
	// software register offsets
	localparam logic [3:0] REG_CONTROL = 4'h0;
	localparam logic [3:0] REG_PROBE = 4'h4;
	localparam logic [3:0] REG_STATUS = 4'h8;
	// software register reset values
	localparam logic [15:0] CONTROL_RESET = 16'h0001;
	localparam logic [8:0] PROBE_RESET = 9'h000;
	// row phases
	typedef enum logic [1:0] {PH_DISCHARGE, PH_PRECHARGE1, PH_PRECHARGE2, PH_DRIVE} phase_t;
endpackage

// ---- verilog/pixel_mem_if.sv ----
// signals between the timing core and its pixel memory
// assumes both ends run on the same clock
`timescale 1ns/10ps
interface pixel_mem_if #(parameter int AW = 15, parameter int DW = 8);
	logic we; // write one byte this cycle
	logic [AW-1:0] waddr; // write address
	logic [DW-1:0] wdata; // write byte
	logic [AW-1:0] raddr; // read address, data one cycle later
	logic [DW-1:0] rdata; // registered read data
	modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
	modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// ---- verilog/pixel_memory.sv ----
// one write port, one registered read port byte memory for pixel data
// assumes the controller keeps addresses below DEPTH
`timescale 1ns/10ps
module pixel_memory #(
	parameter int DEPTH = 25600
) (
	input wire logic i_clock,
	pixel_mem_if.mem port
);
	// storage, two pixels per byte
	logic [7:0] store [DEPTH];

	// write side
	always_ff @(posedge i_clock) begin
		if (port.we) begin
			store[port.waddr] <= port.wdata;
		end
	end

	// read side comes out of a register
	always_ff @(posedge i_clock) begin
		port.rdata <= store[port.raddr];
	end
endmodule

// ---- verilog/oled_row_scan_grayscale_timing.sv ----
// row scan and grayscale timing core of the panel driver, with byte steering
// assumes host bytes and software strobes are synchronous to i_clock
// Notes on behaviour
// - data select high stores pixel, low decodes command
// - source select chooses oscillator or external clock
// - display clock divides by low nibble plus one
// - high nibble raises oscillator frequency
// - multiplex ratio sets scanned rows, reset 159
// - frame length grows with top gray setting
// - reset loads all documented default settings
// - contrast scales segment current, default 7Fh
// - rows scanned in turn; off pixel resets
// - phase one discharges for programmed length
// - phase two precharges for programmed length
// - phase three length from own command
// - phase four drives gray width, repeats
// - level zero nothing, level one precharge
// - linear table gives level n four n
// - table settings up to 63 clocks
// - outputs enable after display on delay
//
// Decided for this implementation: the strobed register port and the register offsets.
`timescale 1ns/10ps
module oled_row_scan_grayscale_timing #(
	parameter int DISPLAY_ON_CYCLES = oled_pkg::DISPLAY_ON_DELAY_CYCLES,
	parameter int MEM_DEPTH = oled_pkg::PIXEL_BYTES
) (
	input wire logic i_clock,
	input wire logic i_reset_n,
	input wire logic i_clock_source_select,
	input wire logic i_external_clock_input,
	input wire logic [7:0] i_host_byte,
	input wire logic i_host_byte_valid,
	input wire logic i_data_select,
	input wire logic [3:0] i_reg_addr,
	input wire logic [15:0] i_reg_wdata,
	input wire logic i_reg_write,
	input wire logic i_reg_read,
	output logic [15:0] o_reg_rdata,
	output logic o_frame_sync_output,
	output logic [7:0] o_row_select,
	output logic [1:0] o_phase,
	output logic o_outputs_enable,
	output logic o_seg_discharge,
	output logic o_seg_precharge,
	output logic o_seg_current_on,
	output logic o_seg_reset_switch,
	output logic [7:0] o_current_scale
);
	localparam int DW = $clog2(DISPLAY_ON_CYCLES + 1);

	// larger of two phase lengths
	function automatic logic [6:0] max7(input logic [6:0] a, input logic [6:0] b);
		max7 = (a > b) ? a : b;
	endfunction
	// a zero nibble counts as one display clock
	function automatic logic [6:0] len_of(input logic [3:0] n);
		len_of = (n == 4'h0) ? 7'h01 : {3'h0, n};
	endfunction

	pixel_mem_if #(.AW(15), .DW(8)) mif ();
	pixel_memory #(.DEPTH(MEM_DEPTH)) u_mem (.i_clock(i_clock), .port(mif));

	logic [7:0] clock_setup; // oscillator nibble and divide nibble
	logic [7:0] phase_length; // phase two and phase one lengths
	logic [7:0] phase3_length; // second precharge length
	logic [7:0] mux_ratio; // last scanned row
	logic [7:0] contrast; // segment current scale
	logic display_on; // display on command seen
	logic inverse; // inverse display mode
	logic [5:0] gray [16]; // gray table
	logic [7:0] cmd; // command awaiting parameters
	logic [4:0] params_left; // parameter bytes still expected
	logic [3:0] gray_index; // next gray entry to load
	logic [14:0] column_ptr; // pixel write pointer
	logic [15:0] control; // bit0 enables scanning
	logic [8:0] probe_col; // observed segment column
	logic [DW-1:0] on_delay; // display on countdown
	logic ext_prev; // last external clock level
	logic [4:0] osc_cnt; // oscillator model counter
	logic [3:0] div_cnt; // display clock divider
	oled_pkg::phase_t phase; // current row phase
	logic [6:0] phase_cnt; // display clocks into phase
	logic [7:0] row; // scanned row

	// clock selection and division
	logic ext_rise;
	logic osc_tick;
	logic op_tick;
	logic display_clock_tick;
	logic [4:0] osc_period;
	assign ext_rise = i_external_clock_input & ~ext_prev;
	assign osc_period = oled_pkg::OSC_PERIOD_BASE - {1'b0, clock_setup[7:4]};
	assign osc_tick = (osc_cnt == osc_period - 5'h01);
	assign op_tick = i_clock_source_select ? osc_tick : ext_rise;
	assign display_clock_tick = op_tick && (div_cnt == clock_setup[3:0]);

	// phase lengths in display clocks
	logic [6:0] len_p1;
	logic [6:0] len_p2;
	logic [6:0] len_p3;
	logic [6:0] len_p4;
	logic [6:0] cur_len;
	assign len_p1 = len_of(phase_length[3:0]);
	assign len_p2 = len_of(phase_length[7:4]);
	assign len_p3 = len_of(phase3_length[3:0]);
	// drive window stretches when the top gray setting outgrows it
	assign len_p4 = max7(oled_pkg::DRIVE_CLOCKS, len_p3 + {1'b0, gray[15]}) - len_p3;
	always_comb begin
		case (phase)
			oled_pkg::PH_DISCHARGE: cur_len = len_p1;
			oled_pkg::PH_PRECHARGE1: cur_len = len_p2;
			oled_pkg::PH_PRECHARGE2: cur_len = len_p3;
			default: cur_len = len_p4;
		endcase
	end

	// oscillator model and external edge detect
	always_ff @(posedge i_clock) begin
		if (!i_reset_n) begin
			osc_cnt <= 5'h00;
			ext_prev <= 1'b0;
		end else begin
			ext_prev <= i_external_clock_input;
			// oscillator held still while the external source is used
			if (!i_clock_source_select || osc_tick) begin
				osc_cnt <= 5'h00;
			end else begin
				osc_cnt <= osc_cnt + 5'h01;
			end
		end
	end

	// display clock divider
	always_ff @(posedge i_clock) begin
		if (!i_reset_n) begin
			div_cnt <= 4'h0;
		end else if (display_clock_tick) begin
			div_cnt <= 4'h0;
		end else if (op_tick) begin
			div_cnt <= div_cnt + 4'h1;
		end
	end

	// row phase sequencer, advanced by display clocks
	always_ff @(posedge i_clock) begin
		if (!i_reset_n) begin
			phase <= oled_pkg::PH_DISCHARGE;
			phase_cnt <= 7'h00;
			row <= 8'h00;
		end else if (display_clock_tick && control[0]) begin
			if (phase_cnt == cur_len - 7'h01) begin
				phase_cnt <= 7'h00;
				case (phase)
					oled_pkg::PH_DISCHARGE: phase <= oled_pkg::PH_PRECHARGE1;
					oled_pkg::PH_PRECHARGE1: phase <= oled_pkg::PH_PRECHARGE2;
					oled_pkg::PH_PRECHARGE2: phase <= oled_pkg::PH_DRIVE;
					default: begin
						// back to discharge for the next row
						phase <= oled_pkg::PH_DISCHARGE;
						row <= (row >= mux_ratio) ? 8'h00 : row + 8'h01;
					end
				endcase
			end else begin
				phase_cnt <= phase_cnt + 7'h01;
			end
		end
	end

	// command decode and pixel steering
	always_ff @(posedge i_clock) begin
		if (!i_reset_n) begin
			clock_setup <= oled_pkg::CLOCK_SETUP_RESET;
			phase_length <= oled_pkg::PHASE_RESET;
			phase3_length <= oled_pkg::PHASE3_RESET;
			mux_ratio <= oled_pkg::MUX_RESET;
			contrast <= oled_pkg::CONTRAST_RESET;
			display_on <= 1'b0;
			inverse <= 1'b0;
			cmd <= 8'h00;
			params_left <= 5'h00;
			gray_index <= 4'h1;
			column_ptr <= 15'h0000;
		end else if (i_host_byte_valid) begin
			if (i_data_select) begin
				// pixel byte, pointer wraps at the end of memory
				column_ptr <= (column_ptr == 15'(MEM_DEPTH - 1)) ? 15'h0000 : column_ptr + 15'h0001;
			end else if (params_left != 5'h00) begin
				// parameter of the pending command
				params_left <= params_left - 5'h01;
				case (cmd)
					oled_pkg::CMD_CLOCK_SETUP: clock_setup <= i_host_byte;
					oled_pkg::CMD_PHASE_LENGTH: phase_length <= i_host_byte;
					oled_pkg::CMD_PHASE3: phase3_length <= i_host_byte;
					oled_pkg::CMD_MUX: mux_ratio <= i_host_byte;
					oled_pkg::CMD_CONTRAST: contrast <= i_host_byte;
					oled_pkg::CMD_GRAY_LOAD: gray_index <= gray_index + 4'h1;
					default: params_left <= 5'h00;
				endcase
			end else begin
				// new command byte
				cmd <= i_host_byte;
				gray_index <= 4'h1;
				case (i_host_byte)
					oled_pkg::CMD_CLOCK_SETUP, oled_pkg::CMD_PHASE_LENGTH, oled_pkg::CMD_PHASE3,
					oled_pkg::CMD_MUX, oled_pkg::CMD_CONTRAST: params_left <= 5'h01;
					oled_pkg::CMD_GRAY_LOAD: params_left <= oled_pkg::GRAY_LOAD_BYTES;
					oled_pkg::CMD_DISPLAY_ON: display_on <= 1'b1;
					oled_pkg::CMD_DISPLAY_OFF: display_on <= 1'b0;
					oled_pkg::CMD_NORMAL: inverse <= 1'b0;
					oled_pkg::CMD_INVERSE: inverse <= 1'b1;
					default: params_left <= 5'h00;
				endcase
			end
		end
	end

	// gray table: linear at reset or on command, loaded entry by entry
	logic gray_linear;
	assign gray_linear = !i_reset_n ||
		(i_host_byte_valid && !i_data_select && params_left == 5'h00 && i_host_byte == oled_pkg::CMD_GRAY_LINEAR);
	always_ff @(posedge i_clock) begin
		for (int i = 0; i < 16; i++) begin
			if (gray_linear) begin
				gray[i] <= 6'(i) * oled_pkg::GRAY_STEP;
			end else if (i_host_byte_valid && !i_data_select && params_left != 5'h00 &&
				cmd == oled_pkg::CMD_GRAY_LOAD && gray_index == 4'(i)) begin
				gray[i] <= i_host_byte[5:0] & oled_pkg::GRAY_MAX;
			end
		end
	end

	// display on delay counter
	always_ff @(posedge i_clock) begin
		if (!i_reset_n || !display_on) begin
			on_delay <= DW'(DISPLAY_ON_CYCLES);
		end else if (on_delay != '0) begin
			on_delay <= on_delay - DW'(1);
		end
	end

	// software registers
	always_ff @(posedge i_clock) begin
		if (!i_reset_n) begin
			control <= oled_pkg::CONTROL_RESET;
			probe_col <= oled_pkg::PROBE_RESET;
		end else if (i_reg_write) begin
			if (i_reg_addr == oled_pkg::REG_CONTROL) begin
				control <= i_reg_wdata;
			end
			if (i_reg_addr == oled_pkg::REG_PROBE) begin
				probe_col <= i_reg_wdata[8:0];
			end
		end
	end

	// read data, valid only in the cycle after the strobe
	always_ff @(posedge i_clock) begin
		if (!i_reset_n || !i_reg_read) begin
			o_reg_rdata <= 16'h0000;
		end else begin
			case (i_reg_addr)
				oled_pkg::REG_CONTROL: o_reg_rdata <= control;
				oled_pkg::REG_PROBE: o_reg_rdata <= {7'h00, probe_col};
				oled_pkg::REG_STATUS: o_reg_rdata <= {3'h0, display_on, o_outputs_enable, o_frame_sync_output,
					phase, row};
				default: o_reg_rdata <= 16'h0000;
			endcase
		end
	end

	// memory ports: host writes, scan reads the probed pixel of the row
	assign mif.we = i_host_byte_valid && i_data_select;
	assign mif.waddr = column_ptr;
	assign mif.wdata = i_host_byte;
	assign mif.raddr = 15'(row) * 15'(oled_pkg::BYTES_PER_ROW) + {7'h00, probe_col[8:1]};

	// pixel level, with inverse display applied
	logic [3:0] level;
	logic seg_pre;
	logic seg_cur;
	assign level = (probe_col[0] ? mif.rdata[7:4] : mif.rdata[3:0]) ^ {4{inverse}};
	assign seg_pre = (level != 4'h0) && (phase == oled_pkg::PH_PRECHARGE1 || phase == oled_pkg::PH_PRECHARGE2);
	assign seg_cur = (level > 4'h1) && (phase == oled_pkg::PH_DRIVE) && (phase_cnt < {1'b0, gray[level]});

	// registered panel outputs
	always_ff @(posedge i_clock) begin
		if (!i_reset_n) begin
			o_frame_sync_output <= 1'b0;
			o_row_select <= 8'h00;
			o_phase <= 2'h0;
			o_outputs_enable <= 1'b0;
			o_seg_discharge <= 1'b0;
			o_seg_precharge <= 1'b0;
			o_seg_current_on <= 1'b0;
			o_seg_reset_switch <= 1'b1;
			o_current_scale <= 8'h00;
		end else begin
			o_frame_sync_output <= (row == 8'h00) && control[0];
			o_row_select <= row;
			o_phase <= phase;
			o_outputs_enable <= display_on && (on_delay == '0);
			o_seg_discharge <= (phase == oled_pkg::PH_DISCHARGE);
			o_seg_precharge <= seg_pre;
			o_seg_current_on <= seg_cur;
			o_seg_reset_switch <= (phase == oled_pkg::PH_DISCHARGE) || (level == 4'h0);
			o_current_scale <= seg_cur ? contrast : 8'h00;
		end
	end

	// checks
	div_on_op_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
		(op_tick && !display_clock_tick) |=> (div_cnt == $past(div_cnt) + 4'h1))
		else $error("divider missed an operating tick");
	ext_source_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
		(!i_clock_source_select && op_tick) |-> (i_external_clock_input && !ext_prev))
		else $error("tick without external edge");
	row_range_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
		$changed(row) |-> (row == 8'h00 || row == $past(row) + 8'h01))
		else $error("row skipped");
	phase_order_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
		($past(phase) == oled_pkg::PH_DISCHARGE && phase != oled_pkg::PH_DISCHARGE) |->
		phase == oled_pkg::PH_PRECHARGE1)
		else $error("discharge not followed by precharge");
	drive_wrap_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
		($past(phase) == oled_pkg::PH_DRIVE && phase != oled_pkg::PH_DRIVE) |->
		(phase == oled_pkg::PH_DISCHARGE && $changed(row) || mux_ratio == 8'h00))
		else $error("drive did not return to discharge");
	gray_zero_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
		(level == 4'h0) |=> (!o_seg_precharge && !o_seg_current_on && o_seg_reset_switch))
		else $error("level zero driven");
	reset_load_a: assert property (@(posedge i_clock) (!i_reset_n) |=>
		(contrast == oled_pkg::CONTRAST_RESET && mux_ratio == oled_pkg::MUX_RESET && !display_on &&
		gray[15] == 6'h3C))
		else $error("reset defaults wrong");
	on_delay_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
		$rose(o_outputs_enable) |-> $past(on_delay == '0 && display_on))
		else $error("outputs enabled early");
	pixel_store_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
		(i_host_byte_valid && i_data_select) |-> mif.we ##1
		(column_ptr == $past(column_ptr) + 15'h0001 || column_ptr == 15'h0000))
		else $error("pixel byte not stored");
endmodule

// ---- tb/host_model.sv ----
// host side model: drives the byte port of the timing core
// assumes the core takes one byte at each rising edge with valid high
`timescale 1ns/10ps
module host_model (
	input wire logic i_clock,
	input wire logic i_frame_sync_output,
	output logic [7:0] o_host_byte,
	output logic o_host_byte_valid,
	output logic o_data_select
);
	// idle bus at time zero
	initial begin
		o_host_byte = 8'h5a;
		o_host_byte_valid = 1'b0;
		o_data_select = 1'b0;
	end
	// bytes back to back, one per edge; released lines show the inverse afterwards
	task automatic send(input logic [7:0] q[$], input logic ds);
		foreach (q[k]) begin
			o_host_byte <= q[k];
			o_data_select <= ds;
			o_host_byte_valid <= 1'b1;
			@(posedge i_clock);
		end
		o_host_byte_valid <= 1'b0;
		o_host_byte <= ~o_host_byte;
		o_data_select <= ~ds;
	endtask
	// a fast host starts after the sync rise, a slow one after its fall
	task automatic wait_frame(input bit slow, output bit ok);
		int n;
		n = 0;
		while (i_frame_sync_output !== 1'b0 && n < 20000) begin
			@(negedge i_clock);
			n++;
		end
		while (i_frame_sync_output !== 1'b1 && n < 20000) begin
			@(negedge i_clock);
			n++;
		end
		while (slow && i_frame_sync_output !== 1'b0 && n < 20000) begin
			@(negedge i_clock);
			n++;
		end
		ok = (n < 20000);
		// hand back just after a rising edge, where the next request may start
		@(posedge i_clock);
	endtask
endmodule

// ---- tb/oled_row_scan_grayscale_timing_bench.sv ----
// self-checking bench of the row scan timing core, random with corner cases
// assumes the package, interface, design files and host model are compiled first
`timescale 1ns/10ps
module oled_row_scan_grayscale_timing_bench;
	localparam int ON_CYCLES = 20; // shortened display on delay
	localparam int LIMIT = 20000; // bound of the row and frame waits
	logic i_clock, i_reset_n, clock_source_select, ext_clk, reg_write, reg_read, data_select, host_valid;
	logic [7:0] host_byte, row, scale, b3, b1, b6, mux, con, pb;
	logic [3:0] reg_addr, lvl;
	logic [15:0] reg_wdata, rdata, rd;
	logic [1:0] phase;
	logic frame_sync, out_en, dis, pre, cur, rsw;
	logic [31:0] lfsr; // random source
	logic [7:0] q[$]; // command bytes
	int mismatches, checks_done, gt[16], ph[4], frame, cur_n, pre_n, top, per, n, col, drv, p1, p2, p3;
	bit ok, src;

	oled_row_scan_grayscale_timing #(.DISPLAY_ON_CYCLES(ON_CYCLES)) dut (
		.i_clock(i_clock), .i_reset_n(i_reset_n), .i_clock_source_select(clock_source_select),
		.i_external_clock_input(ext_clk), .i_host_byte(host_byte), .i_host_byte_valid(host_valid),
		.i_data_select(data_select), .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata),
		.i_reg_write(reg_write), .i_reg_read(reg_read), .o_reg_rdata(rdata),
		.o_frame_sync_output(frame_sync), .o_row_select(row), .o_phase(phase),
		.o_outputs_enable(out_en), .o_seg_discharge(dis), .o_seg_precharge(pre),
		.o_seg_current_on(cur), .o_seg_reset_switch(rsw), .o_current_scale(scale));
	host_model host (.i_clock(i_clock), .i_frame_sync_output(frame_sync), .o_host_byte(host_byte),
		.o_host_byte_valid(host_valid), .o_data_select(data_select));

	// system clock, 50 ns period
	initial begin
		i_clock = 1'b0;
		forever #25 i_clock = ~i_clock;
	end
	// external operating clock: one rising edge every two system clocks
	always @(posedge i_clock) begin
		ext_clk <= ~ext_clk;
	end
	// shift register random source
	function automatic int rnd(input int m);
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		return int'(lfsr[15:0]) % m;
	endfunction
	// system clocks per display clock
	function automatic int clk_per(input logic [7:0] s, input bit internal);
		return (internal ? int'(oled_pkg::OSC_PERIOD_BASE) - int'(s[7:4]) : 2) * (int'(s[3:0]) + 1);
	endfunction
	// one comparison, counted
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// verdict and end of run
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// software write: one strobe cycle
	task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge i_clock);
		reg_write <= 1'b0;
	endtask
	// software read: data stands in the cycle after the strobe
	task automatic reg_rd(input logic [3:0] a, output logic [15:0] d);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge i_clock);
		reg_read <= 1'b0;
		@(negedge i_clock);
		d = rdata;
		@(posedge i_clock);
	endtask
	// one whole frame from a row 0 start: phase, precharge and current counts of row 0
	task automatic measure();
		int bad;
		bad = 0;
		frame = 0;
		cur_n = 0;
		pre_n = 0;
		top = 0;
		n = 0;
		ph = '{0, 0, 0, 0};
		while (row === 8'h00 && n < LIMIT) begin
			@(negedge i_clock);
			n++;
		end
		while (row !== 8'h00 && n < LIMIT) begin
			@(negedge i_clock);
			n++;
		end
		do begin
			if (row === 8'h00) begin
				ph[phase]++;
				// discharge, reset switch and scale of the probed pixel in row 0
				if (dis !== (phase === 2'h0) || rsw !== (phase === 2'h0 || lvl == 4'h0) ||
					scale !== ((cur === 1'b1) ? con : 8'h00)) bad++;
				cur_n += cur;
				pre_n += pre;
			end
			if (row > top) top = row;
			if (frame_sync !== (row === 8'h00) || (cur === 1'b1 && scale !== con)) bad++;
			@(negedge i_clock);
			frame++;
		end while ((row !== 8'h00 || top == 0) && frame < LIMIT);
		check(bad, 0);
		if (n >= LIMIT || frame >= LIMIT) begin
			mismatches++;
			summarize();
		end
		@(posedge i_clock);
	endtask

	initial begin
		lfsr = 32'h0a44_1b7f;
		i_reset_n = 1'b0;
		clock_source_select = 1'b1;
		ext_clk = 1'b0;
		reg_write = 1'b0;
		reg_read = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 16'h0000;
		mismatches = 0;
		checks_done = 0;
		gt[0] = 0;
		for (int i = 0; i < 6; i++) begin
			// corners first: reset phase lengths, levels 0 and 1; then random settings
			src = (i != 3);
			b3 = (i < 2) ? 8'hF0 : {4'(12 + rnd(4)), 4'(rnd(2))};
			b1 = (i < 2) ? oled_pkg::PHASE_RESET : {4'(1 + rnd(15)), 4'(1 + rnd(15))};
			b6 = (i < 2) ? oled_pkg::PHASE3_RESET : 8'(1 + rnd(15));
			mux = (i < 2) ? 8'h03 : 8'(1 + rnd(3));
			con = 8'(1 + rnd(255));
			pb = (i < 2) ? 8'h10 : 8'(rnd(256));
			col = (i < 2) ? i : rnd(2);
			i_reset_n <= 1'b0;
			repeat (12) @(posedge i_clock);
			check({scale, row, phase, cur, pre, dis, rsw, out_en, frame_sync}, 24'h00_0004);
			i_reset_n <= 1'b1;
			clock_source_select <= src;
			@(posedge i_clock);
			for (n = 1; n < 16; n++) gt[n] = n * int'(oled_pkg::GRAY_STEP);
			if (i == 0) begin
				reg_rd(oled_pkg::REG_CONTROL, rd);
				check(rd, oled_pkg::CONTROL_RESET);
				reg_rd(oled_pkg::REG_PROBE, rd);
				check(rd, 16'(oled_pkg::PROBE_RESET));
				reg_wr(4'hC, 16'hFFFF);
				reg_rd(4'hC, rd);
				check(rd, 16'h0000);
			end
			reg_wr(oled_pkg::REG_PROBE, 16'(col));
			reg_rd(oled_pkg::REG_PROBE, rd);
			check(rd, 16'(col));
			q = '{8'hB3, b3, 8'hB1, b1, 8'hB6, b6, 8'hCA, mux, 8'hC1, con};
			if (i == 2 || i == 4) begin
				q.push_back(oled_pkg::CMD_GRAY_LOAD);
				for (n = 1; n < 16; n++) begin
					gt[n] = (n == 15) ? int'(oled_pkg::GRAY_MAX) : gt[n - 1] + rnd(4) + (n > 1);
					q.push_back(8'(gt[n]));
				end
			end
			if (i == 4) begin
				q.push_back(oled_pkg::CMD_GRAY_LINEAR);
				for (n = 1; n < 16; n++) gt[n] = 4 * n;
			end
			q.push_back((i == 5) ? oled_pkg::CMD_INVERSE : oled_pkg::CMD_NORMAL);
			q.push_back(oled_pkg::CMD_DISPLAY_ON);
			host.send(q, 1'b0);
			n = 0;
			while (out_en !== 1'b1 && n < 40) begin
				@(negedge i_clock);
				n++;
			end
			check(n >= ON_CYCLES - 1 && n <= ON_CYCLES + 3, 1);
			if (n >= 40) summarize();
			@(posedge i_clock);
			reg_rd(oled_pkg::REG_STATUS, rd);
			check(rd[12:11], 2'b11);
			host.wait_frame(i % 2, ok);
			check(ok, 1'b1);
			if (!ok) summarize();
			host.send('{pb, 8'hC1}, 1'b1);
			// probed level, inverted in the inverse display case
			lvl = (col ? pb[7:4] : pb[3:0]) ^ {4{i == 5}};
			measure();
			// expectations from the settings just sent
			per = clk_per(b3, src);
			p1 = b1[3:0];
			p2 = b1[7:4];
			p3 = b6[3:0];
			drv = (p3 + gt[15] > int'(oled_pkg::DRIVE_CLOCKS)) ? p3 + gt[15] : int'(oled_pkg::DRIVE_CLOCKS);
			check(frame, (p1 + p2 + drv) * per * (mux + 1));
			check(top, mux);
			check(ph[0], p1 * per);
			check(ph[1], p2 * per);
			check(ph[2], p3 * per);
			check(ph[3], (drv - p3) * per);
			check(cur_n, (lvl > 1) ? gt[lvl] * per : 0);
			check(pre_n, (lvl != 0) ? (p2 + p3) * per : 0);
			// display off drops the outputs enable within two clocks
			if (i == 5) begin
				host.send('{oled_pkg::CMD_DISPLAY_OFF}, 1'b0);
				repeat (2) @(posedge i_clock);
				check(out_en, 1'b0);
			end
		end
		summarize();
	end
endmodule
